// >>> pkg/phy_status_pkg.sv
// constants shared by the status summary and interrupt block
//
// What this block does
// - duplex status is 1 only in full duplex
// - read-only summary register at address 19h
// - bits 10:8 carry the resolved common mode
// - latched bits hold until their register is read
// - link bit 2 latched low until read
// - bit 15 negotiation done, bit 3 speed
// - bit 4 partner able, bit 1 strap-reset enable
// - bit 5 latches high on page received
// - bits 7,14,13,12 latch high on their events
// - bit 0 latches high on jabber
// - bit 11 pause, bit 6 remote fault
// - led shows duplex, interrupt or transmit activity
// - bit 14 enables interrupt mode, resets 0
// - bit 11 masks duplex change, resets 1
// - bit 10 masks speed change, resets 1
// - bit 9 masks link change, resets 1
// - bit 8 master mask blocks all, resets 1
// - bit 3 flags duplex change, read clears
// - bit 2 flags speed change, read clears
// - bit 1 flags link change, read clears
// - bit 0 and pin show unmasked pending change
`default_nettype none

package phy_status_pkg;

  // ****************************************************
  // register addresses
  // ****************************************************
  localparam logic [4:0] ADDR_STATUS_SUMMARY = 5'h19;
  localparam logic [4:0] ADDR_INTERRUPT_CONTROL_STATUS = 5'h1A;

  // ****************************************************
  // status summary fields
  // ****************************************************
  localparam int SUM_AN_COMPLETE = 15;
  localparam int SUM_PAUSE = 11;
  localparam int SUM_MODE_HI = 10;
  localparam int SUM_MODE_LO = 8;
  localparam int SUM_REMOTE_FAULT = 6;
  localparam int SUM_PARTNER_AN = 4;
  localparam int SUM_SPEED = 3;
  localparam int SUM_AN_ENABLED = 1;

  // latched summary bits, bank index order
  localparam int LAT_W = 7;
  localparam int LAT_JABBER = 0;
  localparam int LAT_LINK = 1;
  localparam int LAT_PAGE = 2;
  localparam int LAT_PD_FAULT = 3;
  localparam int LAT_ABILITY = 4;
  localparam int LAT_ACK_DET = 5;
  localparam int LAT_CMPL_ACK = 6;
  localparam logic [LAT_W-1:0] LAT_LOW_MASK = 7'h02;
  localparam int SUM_JABBER = 0;
  localparam int SUM_LINK = 2;
  localparam int SUM_PAGE = 5;
  localparam int SUM_PD_FAULT = 7;
  localparam int SUM_ABILITY = 12;
  localparam int SUM_ACK_DET = 13;
  localparam int SUM_CMPL_ACK = 14;

  // ****************************************************
  // interrupt register fields
  // ****************************************************
  localparam int IRQ_LED_SEL = 15;
  localparam int IRQ_MODE_ON = 14;
  localparam int IRQ_DUP_MASK = 11;
  localparam int IRQ_SPEED_CHANGE_MASK = 10;
  localparam int IRQ_LINK_MASK = 9;
  localparam int IRQ_MASTER_MASK = 8;
  localparam int FLAG_W = 4;
  localparam int IRQ_PENDING = 0;
  localparam int IRQ_LINK_CHG = 1;
  localparam int IRQ_SPD_CHG = 2;
  localparam int IRQ_DUP_CHG = 3;
  localparam logic [FLAG_W-1:0] FLAG_LOW_MASK = 4'h0;

  localparam logic RST_LED_SEL = 1'b0;
  localparam logic RST_MODE_ON = 1'b0;
  localparam logic RST_SRC_MASK = 1'b1;
  localparam logic RST_MASTER_MASK = 1'b1;

  // ****************************************************
  // resolved common mode codes
  // ****************************************************
  localparam logic [2:0] MODE_NONE = 3'h0;
  localparam logic [2:0] MODE_10_HALF = 3'h1;
  localparam logic [2:0] MODE_10_FULL = 3'h2;
  localparam logic [2:0] MODE_100TX_HALF = 3'h3;
  localparam logic [2:0] MODE_100T4 = 3'h4;
  localparam logic [2:0] MODE_100TX_FULL = 3'h5;

  // ****************************************************
  // management frame
  // ****************************************************
  localparam int PREAMBLE_BITS = 32;
  localparam int HEADER_BITS = 13;
  localparam int TURN_BITS = 2;
  localparam int DATA_BITS = 16;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  typedef enum logic [2:0] {
    ST_PREAMBLE,
    ST_HEADER,
    ST_TURN,
    ST_READ,
    ST_WRITE
  } frame_state_t;

endpackage : phy_status_pkg

`default_nettype wire

// >>> hw/latch_bank.sv
// bank of latched-high and latched-low status bits
`default_nettype none

module latch_bank #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] LOW_MASK = '0
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // condition levels and per-bit clear
  input wire logic [WIDTH-1:0] cond,
  input wire logic [WIDTH-1:0] clear,
  // latched value
  output logic [WIDTH-1:0] bits
);

  logic [WIDTH-1:0] next_bits;

  // ****************************************************
  // next value
  // ****************************************************
  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      if (LOW_MASK[i])
      begin
        // a drop holds 0; clear re-arms to the present level
        next_bits[i] = cond[i] & (bits[i] | clear[i]);
      end
      else
      begin
        // the event wins over a clear in the same cycle
        next_bits[i] = cond[i] | (bits[i] & ~clear[i]);
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      bits <= '0;
    end
    else
    begin
      bits <= next_bits;
    end
  end

endmodule : latch_bank

`default_nettype wire

// >>> hw/phy_status_summary_and_interrupt.sv
// status summary and interrupt registers behind the management serial port
`default_nettype none

module phy_status_summary_and_interrupt
  import phy_status_pkg::*;
#(
  parameter int PREAMBLE_LEN = PREAMBLE_BITS
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // management serial interface
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr,
  // auto-negotiation status
  input wire logic autoneg_strap_pin,
  input wire logic autoneg_enabled,
  input wire logic autoneg_complete,
  input wire logic an_complete_ack_state,
  input wire logic an_ack_detected,
  input wire logic an_ability_detect,
  input wire logic pause_resolved,
  input wire logic [2:0] resolved_common_mode,
  input wire logic parallel_detect_fault,
  input wire logic remote_fault,
  input wire logic page_received,
  input wire logic partner_an_able,
  // link, speed, duplex and jabber status
  input wire logic speed_100,
  input wire logic link_pass,
  input wire logic full_duplex,
  input wire logic jabber_detect,
  input wire logic transmit_activity_led,
  // pins
  output logic irq_out_n,
  output logic duplex_led_n
);

  // ****************************************************
  // declarations
  // ****************************************************
  frame_state_t state;
  logic mdc_q;
  logic mdc_rise;
  logic mdc_fall;
  logic [5:0] one_cnt;
  logic [4:0] bit_cnt;
  logic [HEADER_BITS-2:0] hdr;
  logic [HEADER_BITS-1:0] next_hdr;
  logic is_read;
  logic mapped;
  logic [4:0] reg_sel;
  logic [DATA_BITS-1:0] wr_data;
  logic [DATA_BITS-1:0] next_wr_data;
  logic [DATA_BITS-1:0] snap;
  logic read_done;
  logic write_done;
  logic [DATA_BITS-1:0] summary_value;
  logic [DATA_BITS-1:0] irq_value;

  logic duplex_led_select;
  logic irq_mode_on;
  logic duplex_change_mask;
  logic speed_change_mask;
  logic link_change_mask;
  logic master_irq_mask;
  logic an_enabled_bit;

  logic prev_valid;
  logic prev_duplex;
  logic prev_speed;
  logic prev_link;

  logic [LAT_W-1:0] lat_cond;
  logic [LAT_W-1:0] lat_clear;
  logic [LAT_W-1:0] latch_low_high;
  logic [FLAG_W-1:0] flag_cond;
  logic [FLAG_W-1:0] flag_clear;
  logic [FLAG_W-1:0] flags;
  logic duplex_changed;
  logic speed_changed;
  logic link_changed;
  logic irq_pending;
  logic unmasked_change;

  // ****************************************************
  // management clock edges
  // ****************************************************
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      mdc_q <= 1'b0;
    end
    else
    begin
      mdc_q <= mdc;
    end
  end

  assign mdc_rise = mdc & ~mdc_q;
  assign mdc_fall = ~mdc & mdc_q;
  assign next_hdr = {hdr, mdio_in};
  assign next_wr_data = {wr_data[DATA_BITS-2:0], mdio_in};

  // ****************************************************
  // frame receiver
  // ****************************************************
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state <= ST_PREAMBLE;
      one_cnt <= '0;
      bit_cnt <= '0;
      hdr <= '0;
      is_read <= 1'b0;
      mapped <= 1'b0;
      reg_sel <= '0;
      wr_data <= '0;
      snap <= '0;
    end
    else if (mdc_rise)
    begin
      unique case (state)
        ST_PREAMBLE:
        begin
          if (mdio_in)
          begin
            if (int'(one_cnt) < PREAMBLE_LEN)
            begin
              one_cnt <= one_cnt + 6'h01;
            end
          end
          else
          begin
            // this zero is the first start bit
            if (int'(one_cnt) >= PREAMBLE_LEN)
            begin
              state <= ST_HEADER;
              bit_cnt <= '0;
            end
            one_cnt <= '0;
          end
        end
        ST_HEADER:
        begin
          hdr <= next_hdr[HEADER_BITS-2:0];
          bit_cnt <= bit_cnt + 5'h01;
          if (int'(bit_cnt) == HEADER_BITS - 1)
          begin
            bit_cnt <= '0;
            if (next_hdr[HEADER_BITS-1] && next_hdr[9:5] == phy_addr &&
                (next_hdr[11:10] == OP_READ || next_hdr[11:10] == OP_WRITE))
            begin
              state <= ST_TURN;
              is_read <= (next_hdr[11:10] == OP_READ);
              reg_sel <= next_hdr[4:0];
              mapped <= (next_hdr[4:0] == ADDR_STATUS_SUMMARY) ||
                        (next_hdr[4:0] == ADDR_INTERRUPT_CONTROL_STATUS);
              if (next_hdr[4:0] == ADDR_STATUS_SUMMARY)
              begin
                snap <= summary_value;
              end
              else
              begin
                snap <= irq_value;
              end
            end
            else
            begin
              state <= ST_PREAMBLE;
            end
          end
        end
        ST_TURN:
        begin
          bit_cnt <= bit_cnt + 5'h01;
          if (int'(bit_cnt) == TURN_BITS - 1)
          begin
            bit_cnt <= '0;
            state <= is_read ? ST_READ : ST_WRITE;
          end
        end
        ST_READ:
        begin
          bit_cnt <= bit_cnt + 5'h01;
          if (int'(bit_cnt) == DATA_BITS - 1)
          begin
            bit_cnt <= '0;
            state <= ST_PREAMBLE;
          end
        end
        ST_WRITE:
        begin
          wr_data <= next_wr_data;
          bit_cnt <= bit_cnt + 5'h01;
          if (int'(bit_cnt) == DATA_BITS - 1)
          begin
            bit_cnt <= '0;
            state <= ST_PREAMBLE;
          end
        end
      endcase
    end
  end

  assign read_done = mdc_rise && state == ST_READ && mapped &&
                     int'(bit_cnt) == DATA_BITS - 1;
  assign write_done = mdc_rise && state == ST_WRITE && mapped &&
                      int'(bit_cnt) == DATA_BITS - 1;

  // ****************************************************
  // read data driver
  // ****************************************************
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      mdio_oe <= 1'b0;
      mdio_out <= 1'b0;
    end
    else if (mdc_fall)
    begin
      if (state == ST_TURN && is_read && mapped && int'(bit_cnt) == TURN_BITS - 1)
      begin
        mdio_oe <= 1'b1;
        mdio_out <= 1'b0;
      end
      else if (state == ST_READ && mapped)
      begin
        mdio_oe <= 1'b1;
        mdio_out <= snap[4'(DATA_BITS - 1 - int'(bit_cnt))];
      end
      else
      begin
        mdio_oe <= 1'b0;
        mdio_out <= 1'b0;
      end
    end
  end

  // ****************************************************
  // read values
  // ****************************************************
  always_comb
  begin
    summary_value = '0;
    summary_value[SUM_AN_COMPLETE] = autoneg_complete;
    summary_value[SUM_CMPL_ACK] = latch_low_high[LAT_CMPL_ACK];
    summary_value[SUM_ACK_DET] = latch_low_high[LAT_ACK_DET];
    summary_value[SUM_ABILITY] = latch_low_high[LAT_ABILITY];
    summary_value[SUM_PAUSE] = pause_resolved;
    // 11x codes are passed through as the engine gives them
    summary_value[SUM_MODE_HI:SUM_MODE_LO] = resolved_common_mode;
    summary_value[SUM_PD_FAULT] = latch_low_high[LAT_PD_FAULT];
    summary_value[SUM_REMOTE_FAULT] = remote_fault;
    summary_value[SUM_PAGE] = latch_low_high[LAT_PAGE];
    summary_value[SUM_PARTNER_AN] = partner_an_able;
    summary_value[SUM_SPEED] = speed_100;
    summary_value[SUM_LINK] = latch_low_high[LAT_LINK];
    summary_value[SUM_AN_ENABLED] = an_enabled_bit;
    summary_value[SUM_JABBER] = latch_low_high[LAT_JABBER];
  end

  always_comb
  begin
    irq_value = '0;
    irq_value[IRQ_LED_SEL] = duplex_led_select;
    irq_value[IRQ_MODE_ON] = irq_mode_on;
    irq_value[IRQ_DUP_MASK] = duplex_change_mask;
    irq_value[IRQ_SPEED_CHANGE_MASK] = speed_change_mask;
    irq_value[IRQ_LINK_MASK] = link_change_mask;
    irq_value[IRQ_MASTER_MASK] = master_irq_mask;
    irq_value[FLAG_W-1:0] = flags;
  end

  // ****************************************************
  // interrupt control bits
  // ****************************************************
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      duplex_led_select <= RST_LED_SEL;
      irq_mode_on <= RST_MODE_ON;
      duplex_change_mask <= RST_SRC_MASK;
      speed_change_mask <= RST_SRC_MASK;
      link_change_mask <= RST_SRC_MASK;
      master_irq_mask <= RST_MASTER_MASK;
    end
    else if (write_done && reg_sel == ADDR_INTERRUPT_CONTROL_STATUS)
    begin
      // reserved and flag bits of the written word are ignored
      duplex_led_select <= next_wr_data[IRQ_LED_SEL];
      irq_mode_on <= next_wr_data[IRQ_MODE_ON];
      duplex_change_mask <= next_wr_data[IRQ_DUP_MASK];
      speed_change_mask <= next_wr_data[IRQ_SPEED_CHANGE_MASK];
      link_change_mask <= next_wr_data[IRQ_LINK_MASK];
      master_irq_mask <= next_wr_data[IRQ_MASTER_MASK];
    end
  end

  // ****************************************************
  // auto-negotiation enable bit, strap caught in reset
  // ****************************************************
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      an_enabled_bit <= autoneg_strap_pin;
    end
    else
    begin
      an_enabled_bit <= autoneg_enabled;
    end
  end

  // ****************************************************
  // change detection
  // ****************************************************
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      prev_valid <= 1'b0;
      prev_duplex <= 1'b0;
      prev_speed <= 1'b0;
      prev_link <= 1'b0;
    end
    else
    begin
      prev_valid <= 1'b1;
      prev_duplex <= full_duplex;
      prev_speed <= speed_100;
      prev_link <= link_pass;
    end
  end

  assign duplex_changed = prev_valid & (full_duplex != prev_duplex);
  assign speed_changed = prev_valid & (speed_100 != prev_speed);
  assign link_changed = prev_valid & (link_pass != prev_link);

  // ****************************************************
  // latched summary bits
  // ****************************************************
  always_comb
  begin
    lat_cond = '0;
    lat_cond[LAT_JABBER] = jabber_detect;
    lat_cond[LAT_LINK] = link_pass;
    lat_cond[LAT_PAGE] = page_received;
    lat_cond[LAT_PD_FAULT] = parallel_detect_fault;
    lat_cond[LAT_ABILITY] = an_ability_detect;
    lat_cond[LAT_ACK_DET] = an_ack_detected;
    lat_cond[LAT_CMPL_ACK] = an_complete_ack_state;
  end

  // clear only what the finished read showed, so later events stay
  always_comb
  begin
    lat_clear = '0;
    if (read_done && reg_sel == ADDR_STATUS_SUMMARY)
    begin
      lat_clear[LAT_JABBER] = snap[SUM_JABBER];
      // re-arm only a drop the read showed; a later drop must stay 0
      lat_clear[LAT_LINK] = ~snap[SUM_LINK];
      lat_clear[LAT_PAGE] = snap[SUM_PAGE];
      lat_clear[LAT_PD_FAULT] = snap[SUM_PD_FAULT];
      lat_clear[LAT_ABILITY] = snap[SUM_ABILITY];
      lat_clear[LAT_ACK_DET] = snap[SUM_ACK_DET];
      lat_clear[LAT_CMPL_ACK] = snap[SUM_CMPL_ACK];
    end
  end

  latch_bank #(
    .WIDTH(LAT_W),
    .LOW_MASK(LAT_LOW_MASK)
  ) u_summary_latches (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .cond(lat_cond),
    .clear(lat_clear),
    .bits(latch_low_high)
  );

  // ****************************************************
  // change flags and pending interrupt
  // ****************************************************
  // flags being cleared by this read no longer hold the pending bit up
  assign unmasked_change = ~master_irq_mask &
    ((flags[IRQ_DUP_CHG] & ~flag_clear[IRQ_DUP_CHG] & ~duplex_change_mask) |
     (flags[IRQ_SPD_CHG] & ~flag_clear[IRQ_SPD_CHG] & ~speed_change_mask) |
     (flags[IRQ_LINK_CHG] & ~flag_clear[IRQ_LINK_CHG] & ~link_change_mask));

  always_comb
  begin
    flag_cond = '0;
    flag_cond[IRQ_DUP_CHG] = duplex_changed;
    flag_cond[IRQ_SPD_CHG] = speed_changed;
    flag_cond[IRQ_LINK_CHG] = link_changed;
    flag_cond[IRQ_PENDING] = unmasked_change;
  end

  always_comb
  begin
    flag_clear = '0;
    if (read_done && reg_sel == ADDR_INTERRUPT_CONTROL_STATUS)
    begin
      flag_clear = snap[FLAG_W-1:0];
    end
  end

  latch_bank #(
    .WIDTH(FLAG_W),
    .LOW_MASK(FLAG_LOW_MASK)
  ) u_change_flags (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .cond(flag_cond),
    .clear(flag_clear),
    .bits(flags)
  );

  assign irq_pending = flags[IRQ_PENDING];

  // ****************************************************
  // interrupt and shared led pins
  // ****************************************************
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      irq_out_n <= 1'b1;
    end
    else
    begin
      irq_out_n <= ~(irq_mode_on & irq_pending);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      duplex_led_n <= 1'b1;
    end
    else if (duplex_led_select)
    begin
      duplex_led_n <= ~full_duplex;
    end
    else if (irq_mode_on)
    begin
      duplex_led_n <= ~irq_pending;
    end
    else
    begin
      duplex_led_n <= ~transmit_activity_led;
    end
  end

endmodule : phy_status_summary_and_interrupt

`default_nettype wire

// >>> testbench/phy_status_asserts.sv
// pin-level assertions for the status summary and interrupt block
`default_nettype none

module phy_status_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // watched pins
  input wire logic mdc,
  input wire logic mdio_oe,
  input wire logic mdio_out,
  input wire logic full_duplex,
  input wire logic speed_100,
  input wire logic link_pass,
  input wire logic transmit_activity_led,
  input wire logic irq_out_n,
  input wire logic duplex_led_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // ****************************************************
  // helper logic
  // ****************************************************
  logic mdc_q;
  logic [4:0] rises;
  logic [2:0] quiet;
  logic [3:0] lvl_q;
  always_ff @(posedge sys_clk) mdc_q <= mdc;
  always_ff @(posedge sys_clk) lvl_q <= {full_duplex, speed_100, link_pass, transmit_activity_led};
  // mdc rises while the read data is driven
  always_ff @(posedge sys_clk)
    if (!reset_n || !mdio_oe)
      rises <= 5'h00;
    else if (mdc && !mdc_q)
      rises <= rises + 5'h01;
  // cycles with no management clock and no status change
  always_ff @(posedge sys_clk)
    if (!reset_n || mdc || lvl_q != {full_duplex, speed_100, link_pass, transmit_activity_led})
      quiet <= 3'h0;
    else if (quiet != 3'h7)
      quiet <= quiet + 3'h1;

  chk_oe_after_fall: assert property ($rose(mdio_oe) |-> !$past(mdc) && $past(mdc, 2))
    else $error("data enable not two cycles after mdc fall");
  chk_out_on_fall: assert property ($changed(mdio_out) |-> !$past(mdc) && $past(mdc, 2))
    else $error("data out moved away from mdc fall");
  chk_ta_low: assert property ($rose(mdio_oe) |-> !mdio_out)
    else $error("turnaround not driven low");
  chk_idle_out_low: assert property (!mdio_oe |-> !mdio_out)
    else $error("data out high while not driving");
  chk_read_len: assert property ($fell(mdio_oe) |-> rises == 5'h11)
    else $error("read drive length wrong");
  chk_irq_quiet: assert property (quiet >= 3'h5 |-> $stable(irq_out_n))
    else $error("interrupt pin moved without cause");
  chk_led_quiet: assert property (quiet >= 3'h5 |-> $stable(duplex_led_n))
    else $error("led pin moved without cause");
  chk_irq_clear_read: assert property ($rose(irq_out_n) |->
    $past(mdc) || $past(mdc, 2) || $past(mdc, 3) || $past(mdc, 4) || $past(mdc, 5))
    else $error("interrupt released without access");
  chk_irq_off_reset: assert property ($rose(reset_n) |-> irq_out_n [*4])
    else $error("interrupt active after reset");

  cover property ($fell(mdio_oe));
  cover property ($fell(irq_out_n));
  cover property ($changed(duplex_led_n));
endmodule : phy_status_asserts

bind phy_status_summary_and_interrupt phy_status_asserts chk (.sys_clk(sys_clk),
  .reset_n(reset_n), .mdc(mdc), .mdio_oe(mdio_oe), .mdio_out(mdio_out),
  .full_duplex(full_duplex), .speed_100(speed_100), .link_pass(link_pass),
  .transmit_activity_led(transmit_activity_led), .irq_out_n(irq_out_n),
  .duplex_led_n(duplex_led_n));

`default_nettype wire

// >>> testbench/mgmt_station.sv
// station management model that issues serial management frames
`default_nettype none

module mgmt_station
  import phy_status_pkg::*;
#(
  parameter int PRE = 8,
  parameter int HALF = 4
)
(
  // clock
  input wire logic sys_clk,
  // serial management lines
  output logic mdc,
  output logic mdio_drv,
  output logic mdio_en,
  input wire logic mdio_wire
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    mdc = 1'b0;
    mdio_drv = 1'b0;
    mdio_en = 1'b0;
  end

  // ****************************************************
  // one bit: set while mdc low, taken at its rise
  // ****************************************************
  task automatic bit_slot(input logic en, input logic b, output logic s);
    @(negedge sys_clk);
    mdc = 1'b0;
    mdio_en = en;
    mdio_drv = b;
    repeat (HALF) @(negedge sys_clk);
    mdc = 1'b1;
    s = mdio_wire;
    repeat (HALF - 1) @(negedge sys_clk);
  endtask : bit_slot

  task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic s;
    logic [13:0] hdr;
    hdr = {2'b01, op, 5'h01, ra};
    for (int i = 0; i < PRE; i++) bit_slot(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_slot(1'b1, hdr[i], s);
    for (int i = 0; i < 2; i++) bit_slot(op == OP_WRITE, i == 0, s);
    for (int i = 15; i >= 0; i--)
    begin
      bit_slot(op == OP_WRITE, wd[i], s);
      rd[i] = s;
    end
    // mdc stands low between frames and the line is released
    @(negedge sys_clk);
    mdc = 1'b0;
    mdio_en = 1'b0;
    repeat (8) @(negedge sys_clk);
  endtask : frame
endmodule : mgmt_station

`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the status summary and interrupt block
`default_nettype none

module tb_top;
  import phy_status_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [4:0] A_SUM = ADDR_STATUS_SUMMARY;
  localparam logic [4:0] A_IRQ = ADDR_INTERRUPT_CONTROL_STATUS;
  logic sys_clk, reset_n, mdc, mdio_out, mdio_oe, m_drv, m_en, irq_out_n, duplex_led_n;
  logic strap, an_en, spd, link, fdx, tx;
  logic [2:0] mode;
  logic [9:0] st;
  logic [15:0] d;
  int errors = 0;
  int total_checks = 0;
  wire logic mdio_w = mdio_oe ? mdio_out : (m_en ? m_drv : 1'b1);

  phy_status_summary_and_interrupt #(.PREAMBLE_LEN(2)) dut (.sys_clk(sys_clk),
    .reset_n(reset_n), .mdc(mdc), .mdio_in(mdio_w), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .phy_addr(5'h01), .autoneg_strap_pin(strap), .autoneg_enabled(an_en),
    .autoneg_complete(st[0]), .an_complete_ack_state(st[1]), .an_ack_detected(st[2]),
    .an_ability_detect(st[3]), .pause_resolved(st[4]), .resolved_common_mode(mode),
    .parallel_detect_fault(st[5]), .remote_fault(st[6]), .page_received(st[7]),
    .partner_an_able(st[8]), .speed_100(spd), .link_pass(link), .full_duplex(fdx),
    .jabber_detect(st[9]), .transmit_activity_led(tx), .irq_out_n(irq_out_n),
    .duplex_led_n(duplex_led_n));

  mgmt_station #(.PRE(8), .HALF(4)) ms (.sys_clk(sys_clk), .mdc(mdc), .mdio_drv(m_drv),
    .mdio_en(m_en), .mdio_wire(mdio_w));

  // ****************************************************
  // tasks
  // ****************************************************
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask : chk1

  task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
    ms.frame(OP_READ, ra, 16'h0000, d);
    chk16(d, exp);
  endtask : rd

  task automatic rmw(input logic [15:0] val);
    ms.frame(OP_READ, A_IRQ, 16'h0000, d);
    ms.frame(OP_WRITE, A_IRQ, (val & 16'hCF00) | (d & 16'h30F0), d);
  endtask : rmw

  task automatic toggle(input int i);
    @(negedge sys_clk);
    case (i)
      0: fdx = ~fdx;
      1: spd = ~spd;
      default: link = ~link;
    endcase
    repeat (6) @(negedge sys_clk);
  endtask : toggle

  task automatic results;
    if (errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial
  begin
    repeat (40000) @(posedge sys_clk);
    errors++;
    results();
  end

  initial
  begin
    reset_n = 1'b0;
    {strap, an_en, spd, link, fdx, tx, mode, st} = '0;
    strap = 1'b1;
    an_en = 1'b1;
    repeat (5) @(negedge sys_clk);
    reset_n = 1'b1;
    rd(A_IRQ, 16'h0F00);
    rd(A_SUM, 16'h0002);
    chk1(duplex_led_n, 1'b1);
    st = 10'h3FF;
    {mode, spd, link, fdx} = 6'h2F;
    @(negedge sys_clk);
    st = 10'h151;
    repeat (6) @(negedge sys_clk);
    rd(A_SUM, 16'hFDFB);
    rd(A_SUM, 16'h8D5E);
    rd(A_IRQ, 16'h0F0E);
    rd(A_IRQ, 16'h0F00);
    for (int m = 0; m < 8; m++)
    begin
      mode = m[2:0];
      rd(A_SUM, 16'h885E | {5'h00, mode, 8'h00});
    end
    mode = MODE_100TX_FULL;
    link = 1'b0;
    @(negedge sys_clk);
    link = 1'b1;
    repeat (6) @(negedge sys_clk);
    rd(A_SUM, 16'h8D5A);
    rd(A_SUM, 16'h8D5E);
    rd(A_IRQ, 16'h0F02);
    for (int i = 0; i < 3; i++)
    begin
      rmw(16'h4000 | (16'h0800 >> i));
      toggle(i);
      chk1(irq_out_n, 1'b1);
      rd(A_IRQ, 16'h4000 | (16'h0800 >> i) | (16'h0008 >> i));
      rmw(16'h4000);
      toggle(i);
      chk1(irq_out_n, 1'b0);
      chk1(duplex_led_n, 1'b0);
      rd(A_IRQ, 16'h4001 | (16'h0008 >> i));
      chk1(irq_out_n, 1'b1);
    end
    rmw(16'h4100);
    toggle(1);
    chk1(irq_out_n, 1'b1);
    rd(A_IRQ, 16'h4104);
    rmw(16'h0000);
    tx = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk1(duplex_led_n, 1'b0);
    rmw(16'h8000);
    chk1(duplex_led_n, ~fdx);
    toggle(0);
    chk1(duplex_led_n, ~fdx);
    rmw(16'hFFFF);
    rd(A_IRQ, 16'hCF00);
    rd(5'h05, 16'hFFFF);
    ms.frame(OP_WRITE, A_SUM, 16'h0000, d);
    an_en = 1'b0;
    rd(A_SUM, {8'h8D, 4'h5, spd, 1'b0, 2'b00});
    // a reset in mid-run returns the written controls to their reset values
    reset_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    reset_n = 1'b1;
    rd(A_IRQ, 16'h0F00);
    chk1(duplex_led_n, ~tx);
    results();
  end
endmodule : tb_top

`default_nettype wire
